/* File: hdl/status_event_reporting.sv */
`timescale 1ns/10ps
// Status reporting top: two register groups, command port and error queue.
module status_event_reporting
  import status_pkg::*;
#(
  parameter int DEPTH = ERR_DEPTH
) (
  // Clocking.
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Hardware status inputs, asynchronous.
  input wire logic [STAT_W-1:0] oper_status_in,
  input wire logic [STAT_W-1:0] ques_status_in,
  // Command port: one-cycle strobes with selector and data.
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [3:0] cmd_sel,
  input wire logic [STAT_W-1:0] cmd_wdata,
  input wire logic cmd_preset,
  input wire logic instr_reset,
  output logic [ERR_W-1:0] cmd_rdata,
  output logic cmd_rvalid,
  // Error code producer.
  input wire logic err_push,
  input wire logic signed [ERR_W-1:0] err_code,
  output logic err_full,
  // Summary bits to the status byte.
  output logic oper_summary,
  output logic ques_summary
);
  logic [STAT_W-1:0] oper_s1_q, oper_s2_q, ques_s1_q, ques_s2_q;
  logic [STAT_W-1:0] oper_enab, oper_fall, oper_rise, oper_event;
  logic [STAT_W-1:0] ques_enab, ques_fall, ques_rise, ques_event;
  logic rd_oper_ev, rd_ques_ev, rd_queue;
  logic signed [ERR_W-1:0] queue_mem [DEPTH];
  logic [$clog2(DEPTH)-1:0] rd_ptr_q, wr_ptr_q;
  logic [$clog2(DEPTH):0] count_q;
  logic do_pop, do_push;

  // Two-stage synchronisers for the live status pins.
  always_ff @(posedge mclk) begin
    if (rst) begin
      oper_s1_q <= ALL_ZERO;
      oper_s2_q <= ALL_ZERO;
      ques_s1_q <= ALL_ZERO;
      ques_s2_q <= ALL_ZERO;
    end else if (ce) begin
      oper_s1_q <= oper_status_in;
      oper_s2_q <= oper_s1_q;
      ques_s1_q <= ques_status_in;
      ques_s2_q <= ques_s1_q;
    end
  end

  // Destructive read strobes; instr_reset deliberately drives nothing here.
  assign rd_oper_ev = cmd_rd && (cmd_sel == SEL_OPER_EVENT);
  assign rd_ques_ev = cmd_rd && (cmd_sel == SEL_QUES_EVENT);
  assign rd_queue = cmd_rd && (cmd_sel == SEL_QUEUE);

  status_group oper_grp (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .cond(oper_s2_q),
    .preset(cmd_preset),
    .wr_enab(cmd_wr && cmd_sel == SEL_OPER_ENAB),
    .wr_fall(cmd_wr && cmd_sel == SEL_OPER_FALL),
    .wr_rise(cmd_wr && cmd_sel == SEL_OPER_RISE),
    .wdata(cmd_wdata),
    .rd_event(rd_oper_ev),
    .enab_q(oper_enab),
    .fall_q(oper_fall),
    .rise_q(oper_rise),
    .event_q(oper_event),
    .summary(oper_summary)
  );

  status_group ques_grp (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .cond(ques_s2_q),
    .preset(cmd_preset),
    .wr_enab(cmd_wr && cmd_sel == SEL_QUES_ENAB),
    .wr_fall(cmd_wr && cmd_sel == SEL_QUES_FALL),
    .wr_rise(cmd_wr && cmd_sel == SEL_QUES_RISE),
    .wdata(cmd_wdata),
    .rd_event(rd_ques_ev),
    .enab_q(ques_enab),
    .fall_q(ques_fall),
    .rise_q(ques_rise),
    .event_q(ques_event),
    .summary(ques_summary)
  );

  // Error queue; a push to a full queue is dropped unless a pop comes in the same cycle, the producer sees err_full.
  assign do_pop = rd_queue && (count_q != '0);
  assign do_push = err_push && (!err_full || do_pop);
  assign err_full = (count_q == ($clog2(DEPTH)+1)'(DEPTH));

  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_ptr_q <= '0;
      wr_ptr_q <= '0;
      count_q <= '0;
    end else if (ce) begin
      if (do_push) begin
        queue_mem[wr_ptr_q] <= err_code;
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_q <= count_q + 1'b1;
      end else if (do_pop && !do_push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  // Read data register; status parts are zero-extended 15-bit values.
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd_rdata <= '0;
      cmd_rvalid <= 1'b0;
    end else if (ce) begin
      cmd_rvalid <= cmd_rd;
      if (cmd_rd) begin
        unique case (cmd_sel)
          SEL_OPER_COND: cmd_rdata <= {1'b0, oper_s2_q};
          SEL_OPER_ENAB: cmd_rdata <= {1'b0, oper_enab};
          SEL_OPER_EVENT: cmd_rdata <= {1'b0, oper_event};
          SEL_OPER_FALL: cmd_rdata <= {1'b0, oper_fall};
          SEL_OPER_RISE: cmd_rdata <= {1'b0, oper_rise};
          SEL_QUES_COND: cmd_rdata <= {1'b0, ques_s2_q};
          SEL_QUES_ENAB: cmd_rdata <= {1'b0, ques_enab};
          SEL_QUES_EVENT: cmd_rdata <= {1'b0, ques_event};
          SEL_QUES_FALL: cmd_rdata <= {1'b0, ques_fall};
          SEL_QUES_RISE: cmd_rdata <= {1'b0, ques_rise};
          SEL_QUEUE: cmd_rdata <= (count_q != '0) ? queue_mem[rd_ptr_q] : '0;
          default: cmd_rdata <= '0;
        endcase
      end
    end
  end
endmodule

/* File: hdl/status_pkg.sv */
// Constants and types shared by the status reporting block.
package status_pkg;
  localparam int STAT_W = 15;
  localparam int ERR_W = 16;
  localparam int ERR_DEPTH = 8;
  localparam logic [STAT_W-1:0] ALL_ONES = 15'h7fff;
  localparam logic [STAT_W-1:0] ALL_ZERO = 15'h0000;
  // Register selectors on the command port.
  localparam logic [3:0] SEL_OPER_COND = 4'h0;
  localparam logic [3:0] SEL_OPER_ENAB = 4'h1;
  localparam logic [3:0] SEL_OPER_EVENT = 4'h2;
  localparam logic [3:0] SEL_OPER_FALL = 4'h3;
  localparam logic [3:0] SEL_OPER_RISE = 4'h4;
  localparam logic [3:0] SEL_QUES_COND = 4'h5;
  localparam logic [3:0] SEL_QUES_ENAB = 4'h6;
  localparam logic [3:0] SEL_QUES_EVENT = 4'h7;
  localparam logic [3:0] SEL_QUES_FALL = 4'h8;
  localparam logic [3:0] SEL_QUES_RISE = 4'h9;
  localparam logic [3:0] SEL_QUEUE = 4'ha;
  // Power-up values of the writable parts, the same as after preset.
  localparam logic [STAT_W-1:0] RISE_RESET = ALL_ONES;
  localparam logic [STAT_W-1:0] FALL_RESET = ALL_ZERO;
  localparam logic [STAT_W-1:0] ENAB_RESET = ALL_ZERO;
endpackage

/* File: hdl/status_group.sv */
`timescale 1ns/10ps
// One condition/transition/event/enable register group.
module status_group
  import status_pkg::*;
(
  // Clocking.
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Live condition, already synchronised.
  input wire logic [STAT_W-1:0] cond,
  // Control.
  input wire logic preset,
  input wire logic wr_enab,
  input wire logic wr_fall,
  input wire logic wr_rise,
  input wire logic [STAT_W-1:0] wdata,
  input wire logic rd_event,
  // State.
  output logic [STAT_W-1:0] enab_q,
  output logic [STAT_W-1:0] fall_q,
  output logic [STAT_W-1:0] rise_q,
  output logic [STAT_W-1:0] event_q,
  output logic summary
);
  logic [STAT_W-1:0] cond_prev_q;
  logic [STAT_W-1:0] hit;

  // Previous condition for edge detection.
  always_ff @(posedge mclk) begin
    if (rst) begin
      cond_prev_q <= ALL_ZERO;
    end else if (ce) begin
      cond_prev_q <= cond;
    end
  end

  // Edges passed by the transition filters.
  assign hit = (cond & ~cond_prev_q & rise_q) | (~cond & cond_prev_q & fall_q);

  // Filters and mask; preset has priority over a write in the same cycle.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rise_q <= RISE_RESET;
      fall_q <= FALL_RESET;
      enab_q <= ENAB_RESET;
    end else if (ce) begin
      if (preset) begin
        rise_q <= ALL_ONES;
        fall_q <= ALL_ZERO;
        enab_q <= ALL_ZERO;
      end else begin
        if (wr_rise) begin
          rise_q <= wdata;
        end
        if (wr_fall) begin
          fall_q <= wdata;
        end
        if (wr_enab) begin
          enab_q <= wdata;
        end
      end
    end
  end

  // Sticky events; a new hit beats the read clear so it is never lost.
  always_ff @(posedge mclk) begin
    if (rst) begin
      event_q <= ALL_ZERO;
    end else if (ce) begin
      if (rd_event) begin
        event_q <= hit;
      end else begin
        event_q <= event_q | hit;
      end
    end
  end

  assign summary = |(event_q & enab_q);
endmodule

/* File: testbench/status_event_reporting_props.sv */
// Checker for the command port, error queue flags and summary bits.
`timescale 1ns/10ps
module status_event_reporting_props
  import status_pkg::*;
#(parameter int DEPTH = ERR_DEPTH) (
  // Clock and requests.
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [3:0] cmd_sel,
  input wire logic cmd_preset,
  input wire logic err_push,
  // Answers.
  input wire logic [ERR_W-1:0] cmd_rdata,
  input wire logic cmd_rvalid,
  input wire logic err_full,
  input wire logic oper_summary,
  input wire logic ques_summary
);
  // One domain, so clock and reset are given once.
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  rvalid_timing_a: assert property (ce && cmd_rd |=> cmd_rvalid) else $error("read unanswered");
  rvalid_cause_a: assert property (cmd_rvalid |-> $past(cmd_rd)) else $error("stray rvalid");
  status_width_a: assert property (cmd_rvalid && $past(cmd_sel) != SEL_QUEUE |-> !cmd_rdata[15])
    else $error("bit 15 set");
  preset_mask_a: assert property (ce && cmd_preset |=> !oper_summary && !ques_summary)
    else $error("summary after preset");
  oper_sticky_a: assert property (oper_summary && !(cmd_rd || cmd_wr || cmd_preset) |=> oper_summary)
    else $error("oper summary lost");
  ques_sticky_a: assert property (ques_summary && !(cmd_rd || cmd_wr || cmd_preset) |=> ques_summary)
    else $error("ques summary lost");
  full_hold_a: assert property (err_full && !cmd_rd |=> err_full) else $error("full dropped");
  empty_hold_a: assert property (!err_full && !err_push |=> !err_full) else $error("full raised");
  // Main scenarios reached.
  cover property (oper_summary);
  cover property (ques_summary);
  cover property (err_full && err_push);
endmodule
bind status_event_reporting status_event_reporting_props #(.DEPTH(DEPTH)) i_props (.mclk, .rst, .ce, .cmd_wr,
  .cmd_rd, .cmd_sel, .cmd_preset, .err_push, .cmd_rdata, .cmd_rvalid, .err_full, .oper_summary, .ques_summary);

/* File: testbench/status_event_reporting_tb_top.sv */
// Self-checking bench for the status reporting block.
`timescale 1ns/10ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin error_cnt++; $display("FAIL %s %h %h", n, e, a); end end
module status_event_reporting_tb_top
  import status_pkg::*;
;
  localparam int DEPTH = 4;
  logic mclk = 0, rst = 1, ce = 1, cmd_wr = 0, cmd_rd = 0, cmd_preset = 0, instr_reset = 0, err_push = 0;
  logic [3:0] cmd_sel = 0;
  logic [STAT_W-1:0] cmd_wdata = 0, oper_status_in = 0, ques_status_in = 0;
  logic signed [ERR_W-1:0] err_code = 0;
  logic [ERR_W-1:0] cmd_rdata;
  logic cmd_rvalid, err_full, oper_summary, ques_summary;
  int error_cnt = 0, tests_run = 0;
  status_event_reporting #(.DEPTH(DEPTH)) i_dut (.mclk, .rst, .ce, .oper_status_in, .ques_status_in, .cmd_wr,
    .cmd_rd, .cmd_sel, .cmd_wdata, .cmd_preset, .instr_reset, .cmd_rdata, .cmd_rvalid, .err_push, .err_code,
    .err_full, .oper_summary, .ques_summary);
  // Free-running 20 MHz clock.
  always #25 mclk = ~mclk;
  // Strobes last one cycle; reads are judged once the answering edge has settled.
  task automatic wr(input logic [3:0] s, input logic [STAT_W-1:0] v);
    @(posedge mclk);
    cmd_wr <= 1;
    cmd_sel <= s;
    cmd_wdata <= v;
    @(posedge mclk);
    cmd_wr <= 0;
  endtask
  task automatic rd(input logic [3:0] s, input logic [ERR_W-1:0] e, input string n);
    @(posedge mclk);
    cmd_rd <= 1;
    cmd_sel <= s;
    @(posedge mclk);
    cmd_rd <= 0;
    #1;
    `CHK("rvalid", 1'b1, cmd_rvalid)
    `CHK(n, e, cmd_rdata)
  endtask
  task automatic push(input logic signed [ERR_W-1:0] c);
    @(posedge mclk);
    err_push <= 1;
    err_code <= c;
    @(posedge mclk);
    err_push <= 0;
    #1;
  endtask
  // Pins are held long enough to pass the two-flop synchroniser and latch.
  task automatic pins(input int g, input logic [STAT_W-1:0] v);
    @(posedge mclk);
    if (g) ques_status_in <= v;
    else oper_status_in <= v;
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task automatic t_edges();
    logic [3:0] b;
    for (int g = 0; g < 2; g++) begin
      b = 4'(g * 5);
      wr(b + SEL_OPER_FALL, 15'h0002);
      wr(b + SEL_OPER_ENAB, 15'h0004);
      pins(g, 15'h0003);
      rd(b + SEL_OPER_COND, 16'h0003, "cond");
      `CHK("masked", 1'b0, g ? ques_summary : oper_summary)
      rd(b + SEL_OPER_EVENT, 16'h0003, "rise");
      rd(b + SEL_OPER_EVENT, 16'h0000, "clear");
      wr(b + SEL_OPER_ENAB, 15'h0002);
      pins(g, 15'h0000);
      `CHK("summary", 1'b1, g ? ques_summary : oper_summary)
      rd(b + SEL_OPER_EVENT, 16'h0002, "fall");
    end
    $display("edge test done");
  endtask
  task automatic t_preset();
    wr(SEL_QUES_ENAB, 15'h1234);
    wr(SEL_OPER_RISE, 15'h0f0f);
    @(posedge mclk);
    instr_reset <= 1;
    @(posedge mclk);
    instr_reset <= 0;
    rd(SEL_QUES_ENAB, 16'h1234, "kept");
    @(posedge mclk);
    cmd_preset <= 1;
    @(posedge mclk);
    cmd_preset <= 0;
    for (int g = 0; g < 2; g++) begin
      rd(4'(g * 5) + SEL_OPER_ENAB, 16'h0000, "enab");
      rd(4'(g * 5) + SEL_OPER_FALL, 16'h0000, "fallf");
      rd(4'(g * 5) + SEL_OPER_RISE, 16'h7fff, "risef");
    end
    $display("preset test done");
  endtask
  // A rise lands in the very cycle that the event register is read: the clear must not eat it.
  task automatic t_race();
    @(posedge mclk);
    oper_status_in <= 15'h0010;
    @(posedge mclk);
    @(posedge mclk);
    cmd_rd <= 1;
    cmd_sel <= SEL_OPER_EVENT;
    @(posedge mclk);
    cmd_rd <= 0;
    #1;
    `CHK("before", 16'h0000, cmd_rdata)
    pins(0, 15'h0000);
    rd(SEL_OPER_EVENT, 16'h0010, "survive");
    $display("race test done");
  endtask
  // The extra push against a full queue must be dropped.
  task automatic t_queue();
    push(16'hfffb);
    rd(SEL_QUEUE, 16'hfffb, "signed");
    for (int i = 1; i <= DEPTH + 1; i++) push(16'(i));
    `CHK("full", 1'b1, err_full)
    for (int i = 1; i <= DEPTH; i++) rd(SEL_QUEUE, 16'(i), "order");
    rd(SEL_QUEUE, 16'h0000, "empty");
    $display("queue test done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Main sequence after reset.
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 0;
    t_edges();
    t_preset();
    t_race();
    t_queue();
    final_report();
  end
  // Watchdog well past the roughly 110 cycles needed.
  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    final_report();
  end
endmodule
